// ### rtl/prfc_pkg.sv
// package: register map, reset values, field positions and timing for the rate frequency counter
package prfc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_THR_FIRST = 8'h2e;
    localparam logic [7:0] ADDR_THR_LAST = 8'h3d;
    localparam logic [7:0] ADDR_WIN_HIGH = 8'h3e;
    localparam logic [7:0] ADDR_WIN_LOW = 8'h3f;
    localparam logic [7:0] ADDR_SPARE_RW = 8'h40;
    localparam logic [7:0] ADDR_STATUS = 8'h41;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h42;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h43;
    localparam logic [7:0] ADDR_SPARE_RO0 = 8'h44;
    localparam logic [7:0] ADDR_SPARE_RO1 = 8'h45;

    // reset values
    localparam logic [7:0] WIN_HIGH_RST = 8'h0c;
    localparam logic [7:0] WIN_LOW_RST = 8'h00;
    localparam logic [7:0] SPARE_RW_RST = 8'h00;
    // threshold bytes at indices 3..15, index 3 in the low byte
    localparam logic [103:0] THR_RST_TAIL = 104'h53_de_1f_de_1c_f0_e4_ef_e1_db_ae_db_1a;

    // field positions
    localparam int WIN_HIGH_MSB = 3;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_MET_BIT = 1;
    localparam int STAT_FRAC_BIT = 2;
    localparam int STAT_REF_BIT = 3;
    localparam int FRAC_BAND = 1;
    localparam int NUM_BANDS = 4;
    localparam int THR_BYTES = 16;

    // reference detector timeout
    localparam int CLK_PERIOD_PS = 8000;
    localparam int REF_TIMEOUT_NS = 1000;
    localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;

    // one band: inclusive low and high limits of the cycle count
    typedef struct packed {
        logic [15:0] low;
        logic [15:0] high;
    } prfc_band_s;

    typedef prfc_band_s [NUM_BANDS-1:0] prfc_band_arr_t;

    // status byte, bit 0 first from the right
    typedef struct packed {
        logic [3:0] rsvd;
        logic ref_present;
        logic frac_rate;
        logic in_band;
        logic done;
    } prfc_status_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_COUNT = 2'b10
    } prfc_state_e;
endpackage : prfc_pkg

// ### rtl/prfc_thresh_mem.sv
// threshold byte store: sixteen writable bytes, registered read, all bands exposed in parallel
`timescale 1ns/1ps
`default_nettype none
module prfc_thresh_mem
    import prfc_pkg::*;
#(
    parameter logic [23:0] THR_RST_HEAD = 24'h000000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write port
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [7:0] wr_data,
    // read port
    input wire logic rd_en,
    input wire logic [3:0] rd_idx,
    output logic [7:0] rd_data,
    // bands for the comparator
    output prfc_band_arr_t bands
);
    logic [7:0] mem [THR_BYTES];
    logic [127:0] rst_all;

    assign rst_all = {THR_RST_TAIL, THR_RST_HEAD};

    // each band is low high byte, low low byte, high high byte, high low byte
    for (genvar b = 0; b < NUM_BANDS; b++) begin : g_band
        assign bands[b].low = {mem[4*b], mem[4*b+1]};
        assign bands[b].high = {mem[4*b+2], mem[4*b+3]};
    end

    // byte store with reset defaults
    always_ff @(posedge clk) begin
        for (int i = 0; i < THR_BYTES; i++) begin
            if (rst) begin
                mem[i] <= rst_all[8*i +: 8];
            end else if (wr_en && wr_idx == 4'(i)) begin
                mem[i] <= wr_data;
            end
        end
    end

    // read data from a flop, loaded only on a read strobe so it stands while the address moves on
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= mem[rd_idx];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    thr_write_a: assert property (wr_en |=> mem[$past(wr_idx)] == $past(wr_data))
        else $error("threshold byte not stored");
endmodule : prfc_thresh_mem
`default_nettype wire

// ### rtl/prfc_top.sv
// rate frequency counter: window timer, divided vco counter, band check and status registers
// Operation
// - count divided vco cycles over the programmed number of reference cycles
// - window length resets to upper nibble 1100, lower byte zero; read/write
// - reference-present bit is 1 only when detector enabled and reference seen
// - fractional-rate bit is 1 when count falls in the fractional hd band
// - in-band bit tells whether latest count sits inside any of four bands
// - done flag is 1 after a finished measurement, 0 otherwise or disabled
// - sixteen-bit read-only count, high byte then low byte registers
// - each band has writable sixteen-bit low and high limits in byte registers
`timescale 1ns/1ps
`default_nettype none
module prfc_top
    import prfc_pkg::*;
#(
    parameter int WIN_W = 12,
    parameter int COUNT_W = 16,
    parameter logic [23:0] THR_RST_HEAD = 24'h000000
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // measured clocks, sampled as levels
    input wire logic REF_CLK_IN,
    input wire logic VCO_DIV_IN,
    // enables
    input wire logic COUNT_ENABLE,
    input wire logic REF_DET_ENABLE,
    // status mirror
    output logic MEASURE_DONE,
    output logic COUNT_IN_BAND
);
    // the register map has room for exactly these widths
    if (WIN_W != 12 || COUNT_W != 16) begin : g_bad_width
        $error("prfc_top supports WIN_W=12 and COUNT_W=16 only");
    end

    localparam logic [7:0] REF_TIMEOUT = 8'(REF_TIMEOUT_CYC);

    prfc_state_e state;
    prfc_state_e next_state;
    logic [7:0] window_length_high;
    logic [7:0] window_length_low;
    logic [7:0] spare_rw;
    logic ref_prev;
    logic vco_prev;
    logic [WIN_W-1:0] ref_cnt;
    logic [COUNT_W-1:0] cycle_acc;
    logic [COUNT_W-1:0] cycle_count;
    logic measure_done;
    logic count_in_band;
    logic fractional_rate_seen;
    logic reference_present;
    logic [7:0] ref_gap;
    logic [7:0] local_rdata;
    logic rd_from_mem;
    prfc_band_arr_t bands;
    logic [7:0] mem_rdata;

    // inclusive band test, used for the any-band flag and the fractional band
    function automatic logic band_hit(input logic [15:0] c, input prfc_band_s b);
        band_hit = (c >= b.low) && (c <= b.high);
    endfunction : band_hit

    function automatic logic [COUNT_W-1:0] sat_inc(input logic [COUNT_W-1:0] v);
        sat_inc = (&v) ? v : v + COUNT_W'(1);
    endfunction : sat_inc

    // decode and datapath
    wire [WIN_W-1:0] window_length = {window_length_high[WIN_HIGH_MSB:0], window_length_low};
    wire [WIN_W-1:0] win_eff = (window_length == '0) ? WIN_W'(1) : window_length;
    wire ref_rise = REF_CLK_IN && !ref_prev;
    wire vco_rise = VCO_DIV_IN && !vco_prev;
    wire counting = (state == ST_COUNT);
    wire win_end = counting && ref_rise && (ref_cnt == win_eff - WIN_W'(1));
    wire [COUNT_W-1:0] final_count = vco_rise ? sat_inc(cycle_acc) : cycle_acc;
    wire any_band = band_hit(final_count, bands[0]) || band_hit(final_count, bands[1])
        || band_hit(final_count, bands[2]) || band_hit(final_count, bands[3]);
    wire frac_band = band_hit(final_count, bands[FRAC_BAND]);
    wire wr_win_high = REG_WR && REG_ADDR == ADDR_WIN_HIGH;
    wire wr_win_low = REG_WR && REG_ADDR == ADDR_WIN_LOW;
    wire wr_spare = REG_WR && REG_ADDR == ADDR_SPARE_RW;
    wire thr_sel = REG_ADDR >= ADDR_THR_FIRST && REG_ADDR <= ADDR_THR_LAST;
    wire [3:0] thr_idx = 4'(REG_ADDR - ADDR_THR_FIRST);
    prfc_status_s status;

    assign status = '{rsvd: 4'h0, ref_present: reference_present, frac_rate: fractional_rate_seen,
                      in_band: count_in_band, done: measure_done};
    assign MEASURE_DONE = measure_done;
    assign COUNT_IN_BAND = count_in_band;
    assign REG_RDATA = rd_from_mem ? mem_rdata : local_rdata;

    prfc_thresh_mem #(
        .THR_RST_HEAD(THR_RST_HEAD)
    ) u_thr (
        .clk(CLK),
        .rst(RST),
        .wr_en(REG_WR && thr_sel),
        .wr_idx(thr_idx),
        .wr_data(REG_WDATA),
        .rd_en(REG_RD),
        .rd_idx(thr_idx),
        .rd_data(mem_rdata),
        .bands(bands)
    );

    // writable window and spare registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            window_length_high <= WIN_HIGH_RST;
            window_length_low <= WIN_LOW_RST;
            spare_rw <= SPARE_RW_RST;
        end else begin
            if (wr_win_high) window_length_high <= REG_WDATA;
            if (wr_win_low) window_length_low <= REG_WDATA;
            if (wr_spare) spare_rw <= REG_WDATA;
        end
    end

    // read mux; unmapped and reserved addresses read zero
    always_ff @(posedge CLK) begin
        if (RST) begin
            local_rdata <= 8'h00;
            rd_from_mem <= 1'b0;
        end else if (REG_RD) begin
            rd_from_mem <= thr_sel;
            case (REG_ADDR)
                ADDR_WIN_HIGH: local_rdata <= window_length_high;
                ADDR_WIN_LOW: local_rdata <= window_length_low;
                ADDR_SPARE_RW: local_rdata <= spare_rw;
                ADDR_STATUS: local_rdata <= status;
                ADDR_COUNT_HIGH: local_rdata <= cycle_count[15:8];
                ADDR_COUNT_LOW: local_rdata <= cycle_count[7:0];
                default: local_rdata <= 8'h00;
            endcase
        end
    end

    // edge detect of the sampled clock inputs
    always_ff @(posedge CLK) begin
        if (RST) begin
            ref_prev <= 1'b0;
            vco_prev <= 1'b0;
        end else begin
            ref_prev <= REF_CLK_IN;
            vco_prev <= VCO_DIV_IN;
        end
    end

    // window sequencer: idle clears, count runs back-to-back windows
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: next_state = COUNT_ENABLE ? ST_COUNT : ST_IDLE;
            ST_COUNT: next_state = COUNT_ENABLE ? ST_COUNT : ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) state <= ST_IDLE;
        else state <= next_state;
    end

    // window timer and cycle accumulator; a new window restarts on the same edge the old one ends
    // a rewritten length restarts the window, so the timer never runs past a shorter setting
    always_ff @(posedge CLK) begin
        if (RST || !counting || win_end || wr_win_high || wr_win_low) begin
            ref_cnt <= '0;
            cycle_acc <= '0;
        end else begin
            if (ref_rise) ref_cnt <= ref_cnt + WIN_W'(1);
            if (vco_rise) cycle_acc <= sat_inc(cycle_acc);
        end
    end

    // result latch; done drops while the counter is disabled
    always_ff @(posedge CLK) begin
        if (RST) begin
            cycle_count <= '0;
            count_in_band <= 1'b0;
            fractional_rate_seen <= 1'b0;
            measure_done <= 1'b0;
        end else if (!COUNT_ENABLE) begin
            measure_done <= 1'b0;
        end else if (win_end) begin
            cycle_count <= final_count;
            count_in_band <= any_band;
            fractional_rate_seen <= frac_band;
            measure_done <= 1'b1;
        end
    end

    // reference detector: absent after a timeout with no reference edge
    always_ff @(posedge CLK) begin
        if (RST || !REF_DET_ENABLE) begin
            ref_gap <= 8'h00;
            reference_present <= 1'b0;
        end else if (ref_rise) begin
            ref_gap <= 8'h00;
            reference_present <= 1'b1;
        end else if (ref_gap >= REF_TIMEOUT) begin
            reference_present <= 1'b0;
        end else begin
            ref_gap <= ref_gap + 8'h01;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    win_reset_a: assert property ($rose(!RST) |-> window_length == 12'hc00)
        else $error("window length reset value wrong");
    win_bound_a: assert property (counting |-> ref_cnt < win_eff)
        else $error("window timer passed programmed length");
    start_clear_a: assert property (win_end |=> cycle_acc == '0 && ref_cnt == '0)
        else $error("count not cleared at window start");
    count_latch_a: assert property (win_end && COUNT_ENABLE |=> cycle_count == $past(final_count))
        else $error("final count not latched");
    done_set_a: assert property (win_end && COUNT_ENABLE |=> measure_done && status.done)
        else $error("done not set after window");
    done_off_a: assert property (!COUNT_ENABLE |=> !measure_done)
        else $error("done set while disabled");
    band_flag_a: assert property (win_end && COUNT_ENABLE |=> count_in_band == $past(any_band))
        else $error("in-band flag wrong");
    frac_band_a: assert property (fractional_rate_seen |-> count_in_band)
        else $error("fractional rate without band hit");
    frac_latch_a: assert property (win_end && COUNT_ENABLE |=> fractional_rate_seen ==
        ($past(final_count) >= $past(bands[FRAC_BAND].low) && $past(final_count) <= $past(bands[FRAC_BAND].high)))
        else $error("fractional flag not latched from its band");
    ref_off_a: assert property (!REF_DET_ENABLE |=> !reference_present)
        else $error("reference present while detector off");
    count_read_a: assert property (REG_RD && REG_ADDR == ADDR_COUNT_HIGH ##1 !rd_from_mem
        |-> REG_RDATA == $past(cycle_count[15:8]))
        else $error("count high byte read wrong");

    window_end_c: cover property (win_end);
    in_band_c: cover property (win_end && any_band);
    frac_c: cover property (win_end && frac_band);
    ref_seen_c: cover property ($rose(reference_present));
endmodule : prfc_top
`default_nettype wire

// ### dv/prfc_top_tb.sv
// self-checking bench for the rate frequency counter: register access and measurement windows
`timescale 1ns/1ps
`default_nettype none
module prfc_top_tb
    import prfc_pkg::*;
;
    logic CLK, RST, REG_WR, REG_RD, REF_CLK_IN, VCO_DIV_IN, COUNT_ENABLE, REF_DET_ENABLE;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
    logic MEASURE_DONE, COUNT_IN_BAND;
    int error_cnt = 0;
    int samples_checked = 0;

    prfc_top u_prfc_top (
        .CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REF_CLK_IN(REF_CLK_IN), .VCO_DIV_IN(VCO_DIV_IN),
        .COUNT_ENABLE(COUNT_ENABLE), .REF_DET_ENABLE(REF_DET_ENABLE),
        .MEASURE_DONE(MEASURE_DONE), .COUNT_IN_BAND(COUNT_IN_BAND)
    );

    // 125 MHz system clock
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    // every input change lands 1 ns after the rising edge, away from sampling
    task automatic tick();
        @(posedge CLK);
        #1;
    endtask : tick

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: %s read %h expected %h", $time, what, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: %s is %b expected %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        tick();
        REG_ADDR = addr;
        REG_WDATA = data;
        REG_WR = 1'b1;
        tick();
        REG_WR = 1'b0;
    endtask : reg_write

    // data is compared the cycle after the strobe, then again after the address has moved on
    task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
        tick();
        REG_ADDR = addr;
        REG_RD = 1'b1;
        tick();
        REG_RD = 1'b0;
        chk_byte(REG_RDATA, exp, $sformatf("register %h", addr));
        REG_ADDR = addr ^ 8'h01;
        tick();
        chk_byte(REG_RDATA, exp, $sformatf("register %h held", addr));
    endtask : check_reg

    // one reference period with k divided vco pulses, never coinciding with the reference rise
    task automatic ref_period(input int k);
        REF_CLK_IN = 1'b1;
        tick();
        REF_CLK_IN = 1'b0;
        repeat (k) begin
            VCO_DIV_IN = 1'b1;
            tick();
            VCO_DIV_IN = 1'b0;
            tick();
        end
        tick();
    endtask : ref_period

    task automatic set_band(input logic [1:0] b, input logic [15:0] lo, input logic [15:0] hi);
        logic [7:0] a;
        a = ADDR_THR_FIRST + {4'h0, b, 2'b00};
        reg_write(a, lo[15:8]);
        reg_write(a + 8'h01, lo[7:0]);
        reg_write(a + 8'h02, hi[15:8]);
        reg_write(a + 8'h03, hi[7:0]);
    endtask : set_band

    // the first window after enable may be partial, so n covers at least two whole windows
    task automatic measure(input logic [7:0] hi, input logic [7:0] lo, input int k, input int n);
        COUNT_ENABLE = 1'b0;
        reg_write(ADDR_WIN_HIGH, hi);
        reg_write(ADDR_WIN_LOW, lo);
        tick();
        COUNT_ENABLE = 1'b1;
        repeat (n) ref_period(k);
    endtask : measure

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // watchdog: the whole sequence needs well under 6000 cycles
    initial begin
        repeat (20000) @(posedge CLK);
        error_cnt++;
        $display("ERROR %0t: sequence did not finish", $time);
        report_and_stop();
    end

    initial begin
        RST = 1'b1;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REF_CLK_IN = 1'b0;
        VCO_DIV_IN = 1'b0;
        COUNT_ENABLE = 1'b0;
        REF_DET_ENABLE = 1'b1;
        repeat (3) @(posedge CLK);
        #1;
        RST = 1'b0;
        // reset values
        check_reg(ADDR_WIN_HIGH, 8'h0c);
        check_reg(ADDR_WIN_LOW, 8'h00);
        check_reg(ADDR_SPARE_RW, 8'h00);
        check_reg(ADDR_STATUS, 8'h00);
        check_reg(8'h31, 8'h1a);
        check_reg(ADDR_THR_LAST, 8'h53);
        check_reg(ADDR_SPARE_RO1, 8'h00);
        chk_bit(MEASURE_DONE, 1'b0, "done pin");
        // access kinds: writable, read-only, reserved
        reg_write(ADDR_WIN_LOW, 8'h5a);
        check_reg(ADDR_WIN_LOW, 8'h5a);
        reg_write(ADDR_SPARE_RW, 8'ha5);
        check_reg(ADDR_SPARE_RW, 8'ha5);
        reg_write(ADDR_STATUS, 8'hff);
        check_reg(ADDR_STATUS, 8'h00);
        reg_write(ADDR_SPARE_RO0, 8'hff);
        check_reg(ADDR_SPARE_RO0, 8'h00);
        // park every band out of reach, then open one at a time
        for (int b = 0; b < 4; b++) begin
            set_band(b[1:0], 16'hffff, 16'hffff);
        end
        check_reg(ADDR_THR_FIRST, 8'hff);
        check_reg(ADDR_THR_LAST, 8'hff);
        // window 4, five pulses per period: count 0x14 sits exactly on the fractional band
        set_band(2'd1, 16'h0014, 16'h0014);
        measure(8'h00, 8'h04, 5, 9);
        check_reg(ADDR_STATUS, 8'h0f);
        check_reg(ADDR_COUNT_HIGH, 8'h00);
        check_reg(ADDR_COUNT_LOW, 8'h14);
        chk_bit(MEASURE_DONE, 1'b1, "done pin");
        chk_bit(COUNT_IN_BAND, 1'b1, "in-band pin");
        // count one below the lower limit of another band
        set_band(2'd1, 16'hffff, 16'hffff);
        set_band(2'd2, 16'h0015, 16'h0020);
        measure(8'h00, 8'h04, 5, 9);
        check_reg(ADDR_STATUS, 8'h09);
        chk_bit(COUNT_IN_BAND, 1'b0, "in-band pin");
        // count on the upper limit of a non-fractional band
        set_band(2'd2, 16'h0000, 16'h0014);
        measure(8'h00, 8'h04, 5, 9);
        check_reg(ADDR_STATUS, 8'h0b);
        // upper nibble from 0x3e with its spare bits set: window 256 gives count 0x0100
        measure(8'hf1, 8'h00, 1, 520);
        check_reg(ADDR_STATUS, 8'h09);
        check_reg(ADDR_COUNT_HIGH, 8'h01);
        check_reg(ADDR_COUNT_LOW, 8'h00);
        check_reg(ADDR_WIN_HIGH, 8'hf1);
        // disabling the counter drops done but keeps the count
        COUNT_ENABLE = 1'b0;
        tick();
        check_reg(ADDR_STATUS, 8'h08);
        chk_bit(MEASURE_DONE, 1'b0, "done pin");
        check_reg(ADDR_COUNT_HIGH, 8'h01);
        // detector off, then on: one reference edge, then silence past the timeout
        REF_DET_ENABLE = 1'b0;
        tick();
        check_reg(ADDR_STATUS, 8'h00);
        REF_DET_ENABLE = 1'b1;
        REF_CLK_IN = 1'b1;
        tick();
        REF_CLK_IN = 1'b0;
        check_reg(ADDR_STATUS, 8'h08);
        repeat (REF_TIMEOUT_CYC + 5) tick();
        check_reg(ADDR_STATUS, 8'h00);
        // zero length counts as one reference cycle: two pulses per window
        measure(8'h00, 8'h00, 2, 4);
        check_reg(ADDR_STATUS, 8'h0b);
        check_reg(ADDR_COUNT_LOW, 8'h02);
        // reset in mid-run restores the defaults and clears the results
        RST = 1'b1;
        repeat (3) tick();
        RST = 1'b0;
        check_reg(ADDR_WIN_HIGH, 8'h0c);
        check_reg(ADDR_WIN_LOW, 8'h00);
        check_reg(ADDR_STATUS, 8'h00);
        check_reg(ADDR_COUNT_LOW, 8'h00);
        check_reg(8'h32, 8'hdb);
        chk_bit(MEASURE_DONE, 1'b0, "done pin");
        report_and_stop();
    end
endmodule : prfc_top_tb
`default_nettype wire
